// File: rtl/mio_defines.svh
/*
 Register indices, field positions, masks and reset values of the
 microcontroller I/O port block.
 Assumes the APB byte address of a register is four times its index.
*/
// Function
// - Direction bit clear gives input, set gives output
// - Pull-up bit clear disables, set enables pull-up
// - Pull-up applies only while pin is input
// - Pin 1.1 input only, direction bit ignored
// - Pin 1.1 has no pull-up, bit unimplemented
// - Reset option makes port 1 bit 1 read one
// - Pin 1.1 is reset input under reset option
// - Pin 5.4 carries buzzer/PWM when timer output enabled
// - Data read gives input levels, write drives outputs; output pins read back their latch instead
// - Direction bits settable and clearable one at a time
`ifndef MIO_DEFINES_SVH
`define MIO_DEFINES_SVH

// Register indices; byte address is index times four
`define MIO_IDX_P0_DIR   8'hb8
`define MIO_IDX_P1_DIR   8'hc1
`define MIO_IDX_P2_DIR   8'hc2
`define MIO_IDX_P5_DIR   8'hc5
`define MIO_IDX_P0_DATA  8'hd0
`define MIO_IDX_P1_DATA  8'hd1
`define MIO_IDX_P2_DATA  8'hd2
`define MIO_IDX_P5_DATA  8'hd5
`define MIO_IDX_P0_PULL  8'he0
`define MIO_IDX_P1_PULL  8'he1
`define MIO_IDX_P2_PULL  8'he2
`define MIO_IDX_P5_PULL  8'he5
`define MIO_IDX_BITOP    8'hf0
`define MIO_IDX_PINSTAT  8'hf1
`define MIO_IDX_FUNCSTAT 8'hf2

// Implemented bits per port
`define MIO_P0_MASK      8'h01
`define MIO_P1_CTL_MASK  8'h0d
`define MIO_P1_DATA_MASK 8'h0f
`define MIO_P2_MASK      8'h03
`define MIO_P5_MASK      8'h10

`define MIO_REG_RST      8'h00

// Pin numbering on the pad vectors
`define MIO_PIN_P00 0
`define MIO_PIN_P10 1
`define MIO_PIN_P11 2
`define MIO_PIN_P12 3
`define MIO_PIN_P13 4
`define MIO_PIN_P20 5
`define MIO_PIN_P21 6
`define MIO_PIN_P54 7

// Bit operation register fields
`define MIO_BITOP_BIT_LSB  0
`define MIO_BITOP_PORT_LSB 4
`define MIO_BITOP_SET      8
`define MIO_BITOP_DATA     9

// Function status register fields
`define MIO_FS_RESET_OPT 0
`define MIO_FS_ALT_P54   1
`define MIO_FS_INT_EN    2

`endif

// File: rtl/mio_pin_cell.sv
/*
 One pad control cell: output enable, driven level and pull-up request.
 Assumes the pad itself resolves pin level from these three signals.
*/
`timescale 1ns/100ps
`default_nettype none

module mio_pin_cell #(
   parameter bit INPUT_ONLY = 1'b0
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Control from registers
   input  wire logic dir,
   input  wire logic pull_bit,
   input  wire logic data,
   // Shared function
   input  wire logic alt_en,
   input  wire logic alt_level,
   // Pad side
   output logic      pad_out,
   output logic      pad_oe_n,
   output logic      pad_pullup
);

   logic drive;

   // Input-only pad never drives, whatever its control bits hold
   assign drive = !INPUT_ONLY && (dir || alt_en);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_out    <= 1'b0;
         pad_oe_n   <= 1'b1;
         pad_pullup <= 1'b0;
      end else begin
         pad_out    <= alt_en ? alt_level : data;
         pad_oe_n   <= !drive;
         pad_pullup <= !INPUT_ONLY && pull_bit && !drive;
      end
   end

endmodule

`default_nettype wire

// File: rtl/mio_pkg.sv
/*
 Types of the microcontroller I/O port block.
 Assumes mio_defines.svh for all numeric constants.
*/
package mio_pkg;

   typedef enum logic [1:0] {
      MIO_PORT0,
      MIO_PORT1,
      MIO_PORT2,
      MIO_PORT5
   } mio_port_t;

   typedef enum logic [2:0] {
      MIO_K_DIR,
      MIO_K_DATA,
      MIO_K_PULL,
      MIO_K_BITOP,
      MIO_K_PINSTAT,
      MIO_K_FUNCSTAT,
      MIO_K_NONE
   } mio_kind_t;

   typedef struct packed {
      mio_kind_t kind;
      mio_port_t port;
   } mio_dec_t;

endpackage

// File: rtl/mio_ports.sv
/*
 Microcontroller I/O port block: direction, pull-up and data registers
 for ports 0, 1, 2 and 5 behind an APB slave, with the eight pad cells.
 Assumes pad inputs are synchronous to pclk and the factory reset-pin
 option, timer and interrupt enables arrive as steady levels.
*/
// Our own choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "mio_defines.svh"

module mio_ports (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Pads
   input  wire logic [7:0]  pin_in,
   output logic      [7:0]  pin_out,
   output logic      [7:0]  pin_oe_n,
   output logic      [7:0]  pin_pullup_en,
   // Factory option and shared functions
   input  wire logic        reset_pin_option,
   input  wire logic        ext_int_enable,
   input  wire logic        timer_counter_run,
   input  wire logic        buzzer_output_enable,
   input  wire logic        pulse_width_output_enable,
   input  wire logic        buzzer_pwm_level,
   // To interrupt and reset logic
   output logic             external_interrupt_input,
   output logic             ext_reset_req
);
   import mio_pkg::*;

   // Address decode, index equals byte address over four
   function automatic mio_dec_t mio_decode(input logic [11:0] a);
      mio_dec_t d;
      logic [7:0] idx;
      d.kind = MIO_K_NONE;
      d.port = MIO_PORT0;
      idx = a[9:2];
      if (a[11:10] != 2'b00 || a[1:0] != 2'b00) begin
         d.kind = MIO_K_NONE;
      end else if (idx == `MIO_IDX_P0_DIR) begin
         d.kind = MIO_K_DIR;
         d.port = MIO_PORT0;
      end else if (idx == `MIO_IDX_P1_DIR) begin
         d.kind = MIO_K_DIR;
         d.port = MIO_PORT1;
      end else if (idx == `MIO_IDX_P2_DIR) begin
         d.kind = MIO_K_DIR;
         d.port = MIO_PORT2;
      end else if (idx == `MIO_IDX_P5_DIR) begin
         d.kind = MIO_K_DIR;
         d.port = MIO_PORT5;
      end else if (idx == `MIO_IDX_P0_DATA) begin
         d.kind = MIO_K_DATA;
         d.port = MIO_PORT0;
      end else if (idx == `MIO_IDX_P1_DATA) begin
         d.kind = MIO_K_DATA;
         d.port = MIO_PORT1;
      end else if (idx == `MIO_IDX_P2_DATA) begin
         d.kind = MIO_K_DATA;
         d.port = MIO_PORT2;
      end else if (idx == `MIO_IDX_P5_DATA) begin
         d.kind = MIO_K_DATA;
         d.port = MIO_PORT5;
      end else if (idx == `MIO_IDX_P0_PULL) begin
         d.kind = MIO_K_PULL;
         d.port = MIO_PORT0;
      end else if (idx == `MIO_IDX_P1_PULL) begin
         d.kind = MIO_K_PULL;
         d.port = MIO_PORT1;
      end else if (idx == `MIO_IDX_P2_PULL) begin
         d.kind = MIO_K_PULL;
         d.port = MIO_PORT2;
      end else if (idx == `MIO_IDX_P5_PULL) begin
         d.kind = MIO_K_PULL;
         d.port = MIO_PORT5;
      end else if (idx == `MIO_IDX_BITOP) begin
         d.kind = MIO_K_BITOP;
      end else if (idx == `MIO_IDX_PINSTAT) begin
         d.kind = MIO_K_PINSTAT;
      end else if (idx == `MIO_IDX_FUNCSTAT) begin
         d.kind = MIO_K_FUNCSTAT;
      end else begin
         d.kind = MIO_K_NONE;
      end
      return d;
   endfunction

   // Implemented control bits of a port; port 1 bit 1 has none
   function automatic logic [7:0] mio_ctl_mask(input mio_port_t p);
      logic [7:0] m;
      m = 8'h00;
      case (p)
         MIO_PORT0: m = `MIO_P0_MASK;
         MIO_PORT1: m = `MIO_P1_CTL_MASK;
         MIO_PORT2: m = `MIO_P2_MASK;
         default:   m = `MIO_P5_MASK;
      endcase
      return m;
   endfunction

   // Implemented data bits of a port
   function automatic logic [7:0] mio_data_mask(input mio_port_t p);
      logic [7:0] m;
      m = 8'h00;
      case (p)
         MIO_PORT0: m = `MIO_P0_MASK;
         MIO_PORT1: m = `MIO_P1_DATA_MASK;
         MIO_PORT2: m = `MIO_P2_MASK;
         default:   m = `MIO_P5_MASK;
      endcase
      return m;
   endfunction

   // Single-bit set or clear on a register byte
   function automatic logic [7:0] mio_bit_apply(input logic [7:0] v,
                                                input logic [2:0] b,
                                                input logic       s,
                                                input logic [7:0] m);
      logic [7:0] r;
      r = v;
      r[b] = s;
      return r & m;
   endfunction

   // Port register bits placed in pad order; pin 1.1 gets none
   function automatic logic [7:0] mio_spread(input logic [7:0] p0,
                                             input logic [7:0] p1,
                                             input logic [7:0] p2,
                                             input logic [7:0] p5);
      logic [7:0] v;
      v = {p5[4], p2[1:0], p1[3:2], 1'b0, p1[0], p0[0]};
      return v;
   endfunction

   // Control state
   logic [7:0] dir_r  [4];
   logic [7:0] pull_r [4];
   logic [7:0] data_r [4];
   logic [31:0] prdata_r;
   logic        int_in_r;
   logic        rst_req_r;

   // Bus decode
   mio_dec_t   dec;
   logic       wr_en;
   logic       rd_setup;
   logic [7:0] wbyte;
   logic [2:0] op_bit;
   mio_port_t  op_port;
   logic       op_set;
   logic       op_data;
   logic [7:0] rd_val;
   logic       wr_dir;
   logic       wr_pull;
   logic       wr_data;
   logic       bit_dir;
   logic       bit_data;

   // Pin view per port
   logic [7:0] in_byte [4];
   logic [7:0] dir_pin;
   logic [7:0] pull_pin;
   logic [7:0] data_pin;
   logic [7:0] alt_pin;
   logic       alt_p54;
   logic       p11_level;
   logic [7:0] pin_stat;

   assign dec      = mio_decode(paddr);
   assign wr_en    = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign wbyte    = pwdata[7:0];
   assign op_bit   = pwdata[`MIO_BITOP_BIT_LSB +: 3];
   assign op_port  = mio_port_t'(pwdata[`MIO_BITOP_PORT_LSB +: 2]);
   assign op_set   = pwdata[`MIO_BITOP_SET];
   assign op_data  = pwdata[`MIO_BITOP_DATA];

   // Write strobes per register kind
   assign wr_dir   = wr_en && dec.kind == MIO_K_DIR;
   assign wr_pull  = wr_en && dec.kind == MIO_K_PULL;
   assign wr_data  = wr_en && dec.kind == MIO_K_DATA;
   assign bit_dir  = wr_en && dec.kind == MIO_K_BITOP && !op_data;
   assign bit_data = wr_en && dec.kind == MIO_K_BITOP && op_data;

   // Zero wait states; unmapped offsets answer with an error
   assign pready  = 1'b1;
   assign pslverr = psel && penable && (dec.kind == MIO_K_NONE);
   assign prdata  = prdata_r;

   // Direction registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            dir_r[i] <= `MIO_REG_RST;
         end
      end else if (wr_dir) begin
         dir_r[dec.port] <= wbyte & mio_ctl_mask(dec.port);
      end else if (bit_dir) begin
         dir_r[op_port] <= mio_bit_apply(dir_r[op_port], op_bit, op_set,
                                         mio_ctl_mask(op_port));
      end
   end

   // Pull-up registers, write only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            pull_r[i] <= `MIO_REG_RST;
         end
      end else if (wr_pull) begin
         pull_r[dec.port] <= wbyte & mio_ctl_mask(dec.port);
      end
   end

   // Output data latches; port 1 bit 1 is read only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            data_r[i] <= `MIO_REG_RST;
         end
      end else if (wr_data) begin
         data_r[dec.port] <= wbyte & mio_ctl_mask(dec.port);
      end else if (bit_data) begin
         data_r[op_port] <= mio_bit_apply(data_r[op_port], op_bit, op_set,
                                          mio_ctl_mask(op_port));
      end
   end

   // Input levels gathered per port
   assign p11_level = reset_pin_option ? 1'b1 : pin_in[`MIO_PIN_P11];

   always_comb begin
      in_byte[MIO_PORT0] = {7'h00, pin_in[`MIO_PIN_P00]};
      in_byte[MIO_PORT1] = {4'h0, pin_in[`MIO_PIN_P13], pin_in[`MIO_PIN_P12],
                            p11_level, pin_in[`MIO_PIN_P10]};
      in_byte[MIO_PORT2] = {6'h00, pin_in[`MIO_PIN_P21], pin_in[`MIO_PIN_P20]};
      in_byte[MIO_PORT5] = {3'h0, pin_in[`MIO_PIN_P54], 4'h0};
   end

   // Read mux: output pins give their latch, input pins their level
   always_comb begin
      rd_val = 8'h00;
      if (dec.kind == MIO_K_DIR) begin
         rd_val = dir_r[dec.port];
      end else if (dec.kind == MIO_K_DATA) begin
         rd_val = ((dir_r[dec.port] & data_r[dec.port]) |
                   (~dir_r[dec.port] & in_byte[dec.port])) &
                  mio_data_mask(dec.port);
      end else if (dec.kind == MIO_K_PINSTAT) begin
         rd_val = pin_stat;
      end else if (dec.kind == MIO_K_FUNCSTAT) begin
         rd_val[`MIO_FS_RESET_OPT] = reset_pin_option;
         rd_val[`MIO_FS_ALT_P54]   = alt_p54;
         rd_val[`MIO_FS_INT_EN]    = ext_int_enable;
      end else begin
         rd_val = 8'h00;
      end
   end

   // Read data captured in the setup phase, shown in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata_r <= {24'h00_0000, rd_val};
      end
   end

   // Register bits spread onto the pads
   assign dir_pin  = mio_spread(dir_r[MIO_PORT0], dir_r[MIO_PORT1], dir_r[MIO_PORT2], dir_r[MIO_PORT5]);
   assign pull_pin = mio_spread(pull_r[MIO_PORT0], pull_r[MIO_PORT1], pull_r[MIO_PORT2], pull_r[MIO_PORT5]);
   assign data_pin = mio_spread(data_r[MIO_PORT0], data_r[MIO_PORT1], data_r[MIO_PORT2], data_r[MIO_PORT5]);

   // Pin 5.4 taken by the buzzer/PWM output
   assign alt_p54 = timer_counter_run &&
                    (buzzer_output_enable || pulse_width_output_enable);
   assign alt_pin = {alt_p54, 7'h00};

   // Pin status: one for every pad that drives
   assign pin_stat = ~pin_oe_n;

   // Pad cells
   for (genvar g = 0; g < 8; g++) begin : g_pin
      mio_pin_cell #(
         .INPUT_ONLY (g == `MIO_PIN_P11)
      ) u_cell (
         .clk        (pclk),
         .rst_n      (presetn),
         .dir        (dir_pin[g]),
         .pull_bit   (pull_pin[g]),
         .data       (data_pin[g]),
         .alt_en     (alt_pin[g]),
         .alt_level  (buzzer_pwm_level),
         .pad_out    (pin_out[g]),
         .pad_oe_n   (pin_oe_n[g]),
         .pad_pullup (pin_pullup_en[g])
      );
   end

   // Interrupt source, gated by its enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_in_r <= 1'b0;
      end else begin
         int_in_r <= ext_int_enable && pin_in[`MIO_PIN_P00];
      end
   end

   // External reset request, pin 1.1 low under the reset option
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_req_r <= 1'b0;
      end else begin
         rst_req_r <= reset_pin_option && !pin_in[`MIO_PIN_P11];
      end
   end

   assign external_interrupt_input = int_in_r;
   assign ext_reset_req            = rst_req_r;

endmodule

`default_nettype wire

// File: test/mio_ports_properties.sv
/*
 Concurrent checks on the pad, option and read outputs of the I/O port block.
 Assumes binding into mio_ports and a single pclk domain.
*/
`timescale 1ns/100ps
`default_nettype none

module mio_ports_properties (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // Pads
   input wire logic [7:0]  pin_in,
   input wire logic [7:0]  pin_out,
   input wire logic [7:0]  pin_oe_n,
   input wire logic [7:0]  pin_pullup_en,
   // Options and shared functions
   input wire logic        reset_pin_option,
   input wire logic        ext_int_enable,
   input wire logic        timer_counter_run,
   input wire logic        buzzer_output_enable,
   input wire logic        pulse_width_output_enable,
   input wire logic        buzzer_pwm_level,
   input wire logic        external_interrupt_input,
   input wire logic        ext_reset_req
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic alt_on;
   assign alt_on = timer_counter_run && (buzzer_output_enable || pulse_width_output_enable);

   input_only_a: assert property (pin_oe_n[2])
      else $error("reset pin driven");
   no_pull_a: assert property (!pin_pullup_en[2])
      else $error("reset pin pulled up");
   pull_input_a: assert property ((~pin_oe_n & pin_pullup_en) == 8'h00)
      else $error("pull-up on driving pin");
   int_feed_a: assert property ($past(presetn) |->
      external_interrupt_input == $past(ext_int_enable && pin_in[0]))
      else $error("interrupt feed wrong");
   reset_req_a: assert property ($past(presetn) |-> ext_reset_req == $past(reset_pin_option && !pin_in[2]))
      else $error("reset request wrong");
   buzzer_drive_a: assert property ($past(presetn) && $past(alt_on) |->
      !pin_oe_n[7] && pin_out[7] == $past(buzzer_pwm_level))
      else $error("shared output not driven");
   reset_read_a: assert property (psel && !penable && !pwrite && paddr == 12'h344 &&
      reset_pin_option |=> prdata[1])
      else $error("reset pin bit not one");
   dir_write_a: assert property (psel && penable && pwrite && paddr == 12'h2e0 |->
      ##2 pin_oe_n[0] == !$past(pwdata[0], 2))
      else $error("direction write not applied");
endmodule

bind mio_ports mio_ports_properties mio_ports_properties_inst (.*);

`default_nettype wire

// File: test/mio_ports_test.sv
/*
 Self-checking bench of the I/O port block over APB and its pads.
 Assumes the checker is bound in and zero wait states are not relied on.
*/
`timescale 1ns/100ps
`default_nettype none

module mio_ports_test;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  pin_in, pin_out, pin_oe_n, pin_pullup_en;
   logic        reset_pin_option, ext_int_enable, timer_counter_run, buzzer_output_enable;
   logic        pulse_width_output_enable, buzzer_pwm_level, external_interrupt_input, ext_reset_req;
   logic        slverr_seen;
   int          n_fail = 0;
   int          comparisons = 0;
   // Direction, data and pull-up indices per port
   logic [7:0]  reg_idx [3][4] = '{'{8'hb8, 8'hc1, 8'hc2, 8'hc5}, '{8'hd0, 8'hd1, 8'hd2, 8'hd5},
                                   '{8'he0, 8'he1, 8'he2, 8'he5}};
   logic [7:0]  dir_msk [4] = '{8'h01, 8'h0d, 8'h03, 8'h10};

   mio_ports mio_ports_inst (.*);

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic complete_run;
      if (n_fail == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'h0, idx, 2'h0};
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      slverr_seen = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, idx, d, q);
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] q;
      xfer(1'b0, idx, 32'h0, q);
      chk(nm, q[7:0], exp);
   endtask

   task automatic settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask

   task automatic all_wr(input int k, input logic [7:0] v);
      for (int p = 0; p < 4; p++)
         wr(reg_idx[k][p], {24'h0, v});
      settle;
   endtask

   task automatic t_reset;
      chk("oe_n", pin_oe_n, 8'hff);
      chk("pullup", pin_pullup_en, 8'h00);
      for (int p = 0; p < 4; p++) begin
         rd_chk("dir", reg_idx[0][p], 8'h00);
         rd_chk("data", reg_idx[1][p], 8'h00);
      end
      all_wr(0, 8'hff);
      chk("out", pin_out, 8'h00);
      all_wr(0, 8'h00);
   endtask

   task automatic t_dir;
      all_wr(0, 8'hff);
      chk("oe_n", pin_oe_n, 8'h04);
      rd_chk("pinstat", 8'hf1, 8'hfb);
      for (int p = 0; p < 4; p++)
         rd_chk("dir", reg_idx[0][p], dir_msk[p]);
      all_wr(0, 8'h00);
      chk("oe_n", pin_oe_n, 8'hff);
   endtask

   task automatic t_pull;
      all_wr(2, 8'hff);
      chk("pullup", pin_pullup_en, 8'hfb);
      rd_chk("pull", 8'he1, 8'h00);
      wr(8'hc2, 32'h1);
      settle;
      chk("pullup", pin_pullup_en, 8'hdb);
      all_wr(0, 8'h00);
      all_wr(2, 8'h00);
      chk("pullup", pin_pullup_en, 8'h00);
   endtask

   task automatic t_data;
      all_wr(1, 8'hff);
      all_wr(0, 8'hff);
      chk("out", pin_out & 8'hfb, 8'hfb);
      rd_chk("data", 8'hd1, 8'h0d);
      all_wr(0, 8'h00);
      @(posedge pclk);
      pin_in <= 8'h5a;
      rd_chk("data", 8'hd0, 8'h00);
      rd_chk("data", 8'hd1, 8'h0d);
      rd_chk("data", 8'hd2, 8'h02);
      @(posedge pclk);
      reset_pin_option <= 1'b1;
      settle;
      chk("rst_req", {7'h0, ext_reset_req}, 8'h01);
      rd_chk("funcstat", 8'hf2, 8'h01);
      rd_chk("data", 8'hd1, 8'h0f);
      @(posedge pclk);
      reset_pin_option <= 1'b0;
      settle;
      chk("rst_req", {7'h0, ext_reset_req}, 8'h00);
   endtask

   task automatic t_bitop;
      wr(8'hf0, 32'h113);
      rd_chk("dir", 8'hc1, 8'h08);
      wr(8'hf0, 32'h110);
      rd_chk("dir", 8'hc1, 8'h09);
      wr(8'hf0, 32'h013);
      rd_chk("dir", 8'hc1, 8'h01);
      wr(8'hf0, 32'h221);
      wr(8'hf0, 32'h121);
      rd_chk("data", 8'hd2, 8'h00);
      wr(8'hf0, 32'h321);
      rd_chk("data", 8'hd2, 8'h02);
      all_wr(0, 8'h00);
   endtask

   task automatic t_buzz;
      for (int c = 0; c < 8; c++) begin
         @(posedge pclk);
         {timer_counter_run, buzzer_output_enable, pulse_width_output_enable} <= c[2:0];
         buzzer_pwm_level <= c[1];
         settle;
         chk("oe_n", pin_oe_n, (c > 4) ? 8'h7f : 8'hff);
         if (c > 4)
            chk("out7", {7'h0, pin_out[7]}, {7'h0, c[1]});
         rd_chk("funcstat", 8'hf2, (c > 4) ? 8'h02 : 8'h00);
      end
      @(posedge pclk);
      timer_counter_run <= 1'b0;
   endtask

   task automatic t_int;
      @(posedge pclk);
      ext_int_enable <= 1'b1;
      pin_in <= 8'h01;
      settle;
      chk("int", {7'h0, external_interrupt_input}, 8'h01);
      rd_chk("funcstat", 8'hf2, 8'h04);
      @(posedge pclk);
      ext_int_enable <= 1'b0;
      settle;
      chk("int", {7'h0, external_interrupt_input}, 8'h00);
      rd_chk("data", 8'hd0, 8'h01);
   endtask

   task automatic t_unmapped;
      logic [31:0] q;
      xfer(1'b0, 8'h10, 32'h0, q);
      chk("slverr", {7'h0, slverr_seen}, 8'h01);
      chk("rdata", q[7:0], 8'h00);
   endtask

   initial begin
      {psel, penable, pwrite, presetn, reset_pin_option, ext_int_enable} = 6'h0;
      {timer_counter_run, buzzer_output_enable, pulse_width_output_enable, buzzer_pwm_level} = 4'h0;
      {paddr, pwdata, pin_in} = 52'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      settle;
      t_reset;
      t_dir;
      t_pull;
      t_data;
      t_bitop;
      t_buzz;
      t_int;
      t_unmapped;
      all_wr(0, 8'hff);
      all_wr(1, 8'hff);
      all_wr(2, 8'hff);
      @(posedge pclk);
      pin_in <= 8'h00;
      presetn <= 1'b0;
      settle;
      @(posedge pclk);
      presetn <= 1'b1;
      settle;
      t_reset;
      complete_run;
   end

   initial begin
      #40000;
      n_fail++;
      complete_run;
   end
endmodule

`default_nettype wire
